// ### rtl/sftp_monitor.sv
// safety input front end: test pulses, cross faults, stable-time filter
// Behaviour
// - each of the eight ports has two safety inputs and two pulse generators, one per input.
// - on contact ports each generator is on and drops off for 1 ms every 500 ms.
// - contact ports check each input for cross faults against every other input of the module.
// - dual solid-state ports get no cross-fault checking of their cable.
// - solid-state ports hold their generators on with no test pulses, except the first generator in two-wire output mode.
// - every safety input passes a stable-time filter before use, in every port type.
// - each port has one diagnostic input for non-safety status.
// - only ports four to seven also treat that input as a single-wire aux link.
// - those ports detect an attached aux link by itself and report it.
// - in two-wire output mode the first generator output is a second switched channel.
// - first switch-on starts a monitor timer; stable all-on releases, timeout raises a fault.
// - solid-state types use 0.1 s stable time and 2 s monitor time.
// - contact types use 0.5 s stable time and 10 s monitor time.
`timescale 1ns/1ps
`default_nettype none
module sftp_monitor #(
  parameter int SLOT_CYC = sftp_pkg::SLOT_CYC,
  parameter int PERIOD_MS = sftp_pkg::PERIOD_MS,
  parameter int STAGGER_MS = sftp_pkg::STAGGER_MS,
  parameter int STAB_SSO_MS = sftp_pkg::STAB_SSO_MS,
  parameter int MON_SSO_MS = sftp_pkg::MON_SSO_MS,
  parameter int STAB_CONT_MS = sftp_pkg::STAB_CONT_MS,
  parameter int MON_CONT_MS = sftp_pkg::MON_CONT_MS,
  parameter int AUX_IDLE_MS = sftp_pkg::AUX_IDLE_MS
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] SAFE_IN,
  input wire logic [7:0] DIAG_IN,
  output logic [15:0] TP_OUT,
  output logic [7:0] DO_OUT,
  output logic [15:0] SAFE_REL
);
  localparam int NP = sftp_pkg::NPORT;
  localparam int NI = 2 * NP;

  // ****************************************
  // registers and shared nets
  // ****************************************
  logic [15:0] cfg_r;
  logic [7:0] out_r;
  logic [15:0] disc_r;
  logic [15:0] xf_r;
  logic [3:0] aux_r;
  logic [15:0] rel;
  logic [15:0] disc_set;
  logic [15:0] xf_set;
  logic [NI-1:0] pulse_on;
  logic [31:0] slot_cnt_r;
  logic [15:0] ms_cnt_r;
  logic tick;
  logic mid;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic is_contact(input logic [15:0] c, input int p);
    is_contact = c[2*p+1];
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [23:0] s1_r;
  logic [23:0] s2_r;
  logic [23:0] s3_r;
  logic [23:0] flt_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s1_r <= 24'h000000;
      s2_r <= 24'h000000;
      s3_r <= 24'h000000;
      flt_r <= 24'h000000;
    end else begin
      s1_r <= {DIAG_IN, SAFE_IN};
      s2_r <= s1_r;
      s3_r <= s2_r;
      // change taken only where second and third stage agree
      flt_r <= (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
    end
  end

  // ****************************************
  // slot divider and pulse schedule
  // ****************************************
  assign tick = (slot_cnt_r == 32'(SLOT_CYC - 1));
  assign mid = (slot_cnt_r == 32'(SLOT_CYC / 2));

  always_ff @(posedge CLK) begin
    if (RESET) begin
      slot_cnt_r <= 32'h00000000;
      ms_cnt_r <= 16'h0000;
    end else if (tick) begin
      slot_cnt_r <= 32'h00000000;
      ms_cnt_r <= (ms_cnt_r == 16'(PERIOD_MS - 1)) ? 16'h0000 : ms_cnt_r + 16'h0001;
    end else begin
      slot_cnt_r <= slot_cnt_r + 32'h00000001;
    end
  end

  // one slot per generator, each at its own offset in the period
  for (genvar k = 0; k < NI; k++) begin : g_pulse
    assign pulse_on[k] = (ms_cnt_r >= 16'(k * STAGGER_MS)) &&
                         (ms_cnt_r < 16'(k * STAGGER_MS + sftp_pkg::PULSE_MS));
  end

  // ****************************************
  // generator outputs and safety outputs
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      TP_OUT <= 16'hFFFF;
      DO_OUT <= 8'h00;
    end else begin
      for (int k = 0; k < NI; k++) begin
        if (is_contact(cfg_r, k / 2)) begin
          TP_OUT[k] <= ~pulse_on[k];
        end else if (cfg_r[2*(k/2)+:2] == sftp_pkg::PT_SSO_2W && (k % 2) == 0) begin
          TP_OUT[k] <= out_r[k/2];
        end else begin
          TP_OUT[k] <= 1'b1;
        end
      end
      DO_OUT <= out_r;
    end
  end

  // ****************************************
  // pulse masking and cross-fault check
  // ****************************************
  // inputs are judged at mid slot, well clear of the sync delay after a pulse edge
  logic [NI-1:0] hold_r;
  logic [NI-1:0] dip_r;
  logic [NI-1:0] mi;

  for (genvar k = 0; k < NI; k++) begin : g_chan
    logic own;
    logic foreign;
    assign own = pulse_on[k];
    assign foreign = |pulse_on & ~own;
    // own dip is a test artefact, not a switch-off
    assign mi[k] = (is_contact(cfg_r, k / 2) && own) ? hold_r[k] : flt_r[k];
    assign xf_set[k] = mid && is_contact(cfg_r, k / 2) &&
                       ((own && flt_r[k]) || (!foreign && dip_r[k] && flt_r[k]));

    always_ff @(posedge CLK) begin
      if (RESET) begin
        hold_r[k] <= 1'b0;
        dip_r[k] <= 1'b0;
      end else if (mid) begin
        if (!own) begin
          hold_r[k] <= flt_r[k];
        end
        dip_r[k] <= foreign && hold_r[k] && !flt_r[k];
      end
    end
  end

  // ****************************************
  // stable-time filter, one unit per input
  // ****************************************
  for (genvar u = 0; u < NI; u++) begin : g_unit
    localparam int P = u / 2;
    sftp_pkg::sftp_fstate_t st_r;
    logic [15:0] mon_r;
    logic [15:0] stab_r;
    logic on_all;
    logic on_any;
    logic single;
    logic [15:0] stab_lim;
    logic [15:0] mon_lim;

    assign single = (cfg_r[2*P+:2] == sftp_pkg::PT_CONT_1CH);
    // odd unit only works for two independent single channels
    assign on_all = (u % 2 == 1) ? (single && mi[u]) :
                    (single ? mi[u] : (mi[u] && mi[u+1]));
    assign on_any = (u % 2 == 1) ? (single && mi[u]) :
                    (single ? mi[u] : (mi[u] || mi[u+1]));
    assign stab_lim = is_contact(cfg_r, P) ? 16'(STAB_CONT_MS) : 16'(STAB_SSO_MS);
    assign mon_lim = is_contact(cfg_r, P) ? 16'(MON_CONT_MS) : 16'(MON_SSO_MS);
    assign rel[u] = (st_r == sftp_pkg::FS_RUN);
    assign disc_set[u] = mid && (st_r == sftp_pkg::FS_MON) &&
                         (mon_r >= mon_lim - 16'h0001) && !(on_all && stab_r >= stab_lim - 16'h0001);

    always_ff @(posedge CLK) begin
      if (RESET) begin
        st_r <= sftp_pkg::FS_IDLE;
        mon_r <= 16'h0000;
        stab_r <= 16'h0000;
      end else if (mid) begin
        case (st_r)
          sftp_pkg::FS_IDLE: begin
            mon_r <= 16'h0000;
            stab_r <= 16'h0000;
            if (on_any) begin
              st_r <= sftp_pkg::FS_MON;
              mon_r <= 16'h0001;
              stab_r <= on_all ? 16'h0001 : 16'h0000;
            end
          end
          sftp_pkg::FS_MON: begin
            mon_r <= mon_r + 16'h0001;
            stab_r <= on_all ? stab_r + 16'h0001 : 16'h0000;
            if (on_all && stab_r >= stab_lim - 16'h0001) begin
              st_r <= sftp_pkg::FS_RUN;
            end else if (mon_r >= mon_lim - 16'h0001) begin
              st_r <= sftp_pkg::FS_FAULT;
            end
          end
          sftp_pkg::FS_RUN: begin
            if (!on_all) begin
              st_r <= on_any ? sftp_pkg::FS_MON : sftp_pkg::FS_IDLE;
              mon_r <= 16'h0001;
              stab_r <= 16'h0000;
            end
          end
          sftp_pkg::FS_FAULT: begin
            // a latched fault needs all channels off before a new attempt
            if (!on_any) begin
              st_r <= sftp_pkg::FS_IDLE;
            end
          end
          default: begin
            st_r <= sftp_pkg::FS_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // diagnostic inputs and aux link detect
  // ****************************************
  logic [7:0] diag_d_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      diag_d_r <= 8'h00;
    end else begin
      diag_d_r <= flt_r[23:16];
    end
  end

  for (genvar a = 0; a < 4; a++) begin : g_aux
    localparam int P = sftp_pkg::AUX_FIRST + a;
    logic [15:0] idle_r;

    // activity on a plain status line is rare, a link toggles constantly
    always_ff @(posedge CLK) begin
      if (RESET) begin
        aux_r[a] <= 1'b0;
        idle_r <= 16'h0000;
      end else if (flt_r[16+P] != diag_d_r[P]) begin
        aux_r[a] <= 1'b1;
        idle_r <= 16'h0000;
      end else if (tick) begin
        if (idle_r >= 16'(AUX_IDLE_MS - 1)) begin
          aux_r[a] <= 1'b0;
        end else begin
          idle_r <= idle_r + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  logic acc;
  logic done;
  logic [15:0] dclr;
  logic [15:0] xclr;

  assign acc = PSEL && PENABLE;
  assign done = acc && PREADY;
  assign dclr = (done && PWRITE && hit(PADDR, sftp_pkg::OFS_FAULT)) ? PWDATA[15:0] : 16'h0000;
  assign xclr = (done && PWRITE && hit(PADDR, sftp_pkg::OFS_FAULT)) ? PWDATA[31:16] : 16'h0000;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg_r <= sftp_pkg::CFG_RST;
      out_r <= sftp_pkg::OUT_RST;
    end else if (done && PWRITE) begin
      if (hit(PADDR, sftp_pkg::OFS_CFG)) begin
        cfg_r <= PWDATA[15:0];
      end
      if (hit(PADDR, sftp_pkg::OFS_OUT)) begin
        out_r <= PWDATA[7:0];
      end
    end
  end

  // sticky faults: a new event wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      disc_r <= 16'h0000;
      xf_r <= 16'h0000;
    end else begin
      disc_r <= (disc_r & ~dclr) | disc_set;
      xf_r <= (xf_r & ~xclr) | xf_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      SAFE_REL <= 16'h0000;
    end else begin
      SAFE_REL <= rel;
    end
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= acc && !PREADY;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
      if (acc && !PREADY) begin
        if (hit(PADDR, sftp_pkg::OFS_CFG)) begin
          PRDATA <= {16'h0000, cfg_r};
        end else if (hit(PADDR, sftp_pkg::OFS_OUT)) begin
          PRDATA <= {24'h000000, out_r};
        end else if (hit(PADDR, sftp_pkg::OFS_REL)) begin
          PRDATA <= {16'h0000, rel};
        end else if (hit(PADDR, sftp_pkg::OFS_FAULT)) begin
          PRDATA <= {xf_r, disc_r};
        end else if (hit(PADDR, sftp_pkg::OFS_DIAG)) begin
          PRDATA <= {20'h00000, aux_r, diag_d_r};
        end else begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### shared/sftp_pkg.sv
// constants and types shared by the safety input test pulse monitor
`default_nettype none
package sftp_pkg;
  // ****************************************
  // clock and time base
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SLOT_NS = 1000000;
  localparam int unsigned SLOT_CYC = SLOT_NS / CLK_PERIOD_NS;
  // ****************************************
  // times in 1 ms slots
  // ****************************************
  localparam int unsigned PULSE_MS = 1;
  localparam int unsigned PERIOD_MS = 500;
  localparam int unsigned STAGGER_MS = 20;
  localparam int unsigned STAB_SSO_MS = 100;
  localparam int unsigned MON_SSO_MS = 2000;
  localparam int unsigned STAB_CONT_MS = 500;
  localparam int unsigned MON_CONT_MS = 10000;
  localparam int unsigned AUX_IDLE_MS = 50;
  // ****************************************
  // ports
  // ****************************************
  localparam int unsigned NPORT = 8;
  localparam int unsigned AUX_FIRST = 4;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_REL = 8'h08;
  localparam logic [7:0] OFS_FAULT = 8'h0C;
  localparam logic [7:0] OFS_DIAG = 8'h10;
  localparam logic [15:0] CFG_RST = 16'hAAAA;
  localparam logic [7:0] OUT_RST = 8'h00;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PT_SSO_1W = 2'h0,
    PT_SSO_2W = 2'h1,
    PT_CONT_2CH = 2'h2,
    PT_CONT_1CH = 2'h3
  } sftp_ptype_t;
  typedef enum logic [3:0] {
    FS_IDLE = 4'h1,
    FS_MON = 4'h2,
    FS_RUN = 4'h4,
    FS_FAULT = 4'h8
  } sftp_fstate_t;
endpackage
`default_nettype wire

// ### verif/sftp_monitor_asserts.sv
// concurrent checks on the ports of the test pulse monitor
`timescale 1ns/1ps
`default_nettype none
module sftp_monitor_asserts #(
  parameter int SLOT_CYC = 20,
  parameter int PERIOD_MS = 40,
  parameter int STAGGER_MS = 2
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [15:0] TP_OUT,
  input wire logic [7:0] DO_OUT,
  input wire logic [15:0] SAFE_REL
);
  // ****
  // helpers
  // ****
  localparam int PWM1 = SLOT_CYC - 1;
  localparam int ST2 = 2 * STAGGER_MS * SLOT_CYC;
  localparam int PER = PERIOD_MS * SLOT_CYC;
  logic [15:0] gap_r;
  logic seen_r;
  logic [7:0] wd_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  always_ff @(posedge CLK) begin
    if (RESET || $fell(TP_OUT[1])) begin
      gap_r <= 16'h0001;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      seen_r <= 1'b0;
    end else if ($fell(TP_OUT[1])) begin
      seen_r <= 1'b1;
    end
  end
  always_ff @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY && PWRITE && PADDR == sftp_pkg::OFS_OUT) begin
      wd_r <= PWDATA[7:0];
    end
  end
  // ****
  // assertions
  // ****
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_one_wait: assert property (PSEL && $rose(PENABLE) |=> PREADY)
    else $error("ready not after one wait state");
  a_err_resp: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response malformed");
  a_idle_data: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  a_out_copy: assert property (PSEL && PENABLE && PREADY && PWRITE &&
    PADDR == sftp_pkg::OFS_OUT |-> ##[1:2] DO_OUT == wd_r)
    else $error("safety outputs not updated");
  a_reset_state: assert property ($fell(RESET) |->
    TP_OUT == 16'hFFFF && SAFE_REL == 16'h0 && DO_OUT == 8'h00)
    else $error("wrong state after reset");
  a_pulse_len: assert property ($fell(TP_OUT[1]) |-> ##PWM1 !TP_OUT[1] ##1 TP_OUT[1])
    else $error("test pulse length wrong");
  a_pulse_period: assert property ($fell(TP_OUT[1]) && seen_r |-> gap_r == PER)
    else $error("test pulse period wrong");
  a_pulse_stagger: assert property ($fell(TP_OUT[1]) |-> ##ST2 $fell(TP_OUT[3]))
    else $error("test pulses not staggered");
  c_err: cover property (PSLVERR);
  c_rel: cover property ($rose(SAFE_REL[0]));
  c_sso_rel: cover property ($rose(SAFE_REL[10]));
endmodule
bind sftp_monitor sftp_monitor_asserts #(.SLOT_CYC(SLOT_CYC), .PERIOD_MS(PERIOD_MS),
  .STAGGER_MS(STAGGER_MS)) u_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .TP_OUT(TP_OUT), .DO_OUT(DO_OUT), .SAFE_REL(SAFE_REL));
`default_nettype wire

// ### verif/sftp_switch_model.sv
// model of the switchgear wired to the safety inputs
`timescale 1ns/1ps
`default_nettype none
module sftp_switch_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] tp_out,
  input wire logic [15:0] closed,
  input wire logic [15:0] sso_on,
  input wire logic short_en,
  output logic [15:0] safe_in
);
  // ****
  // dips of the solid-state outputs
  // ****
  logic [8:0] dip_cnt_r;
  logic [15:0] cont;
  // dips land at slot start, away from the mid-slot sampling
  always_ff @(posedge clk) begin
    if (rst || dip_cnt_r == 9'h18F) begin
      dip_cnt_r <= 9'h000;
    end else begin
      dip_cnt_r <= dip_cnt_r + 9'h001;
    end
  end
  // open contacts read low: inputs have a pull-down
  always_comb begin
    cont = tp_out & closed;
    safe_in = cont | (sso_on & {16{dip_cnt_r > 9'h001}});
    if (short_en) begin
      safe_in[6] = safe_in[6] | cont[8];
      safe_in[8] = safe_in[8] | cont[6];
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the test pulse monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****
  // signals and tasks
  // ****
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [7:0] DIAG_IN = 8'h00;
  logic [15:0] closed = 16'h0;
  logic [15:0] sso_on = 16'h0;
  logic short_en = 1'b0;
  wire [15:0] SAFE_IN;
  wire [31:0] PRDATA;
  wire PREADY;
  wire PSLVERR;
  wire [15:0] TP_OUT;
  wire [15:0] SAFE_REL;
  wire [7:0] DO_OUT;
  logic [65:0] exp_q[$];
  logic [65:0] e;
  logic [31:0] rnd = 32'h00010860;
  int n_errors = 0;
  int comparisons = 0;
  int n;
  always #5 CLK = ~CLK;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task summarize;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // reads carry the expected word, writes expect only the response
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic er);
    int i;
    exp_q.push_back({w, er, m, d & m});
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (PREADY !== 1'b1 && i < 40);
    if (i >= 40) chk(1'b0, "no ready");
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  always @(posedge CLK) begin
    if (PREADY === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1'b0, "unexpected ready");
      end else begin
        e = exp_q.pop_front();
        chk(PSLVERR === e[64], "bus response");
        if (!e[65]) chk((PRDATA & e[63:32]) === e[31:0], "read data");
      end
    end
  end
  // ****
  // design and switchgear
  // ****
  // period, solid-state monitor time and aux idle time keep their real values
  sftp_monitor #(.SLOT_CYC(20), .STAGGER_MS(2), .STAB_SSO_MS(4),
    .STAB_CONT_MS(8), .MON_CONT_MS(40)) u_sftp_monitor (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SAFE_IN(SAFE_IN), .DIAG_IN(DIAG_IN), .TP_OUT(TP_OUT), .DO_OUT(DO_OUT),
    .SAFE_REL(SAFE_REL));
  sftp_switch_model u_sftp_switch_model (.clk(CLK), .rst(RESET), .tp_out(TP_OUT),
    .closed(closed), .sso_on(sso_on), .short_en(short_en), .safe_in(SAFE_IN));
  // ****
  // tests
  // ****
  initial begin
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    apb(1'b0, sftp_pkg::OFS_CFG, 32'h0000AAAA, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, sftp_pkg::OFS_OUT, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, 8'h14, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 8'h14, 32'h5, 32'h0, 1'b1);
    apb(1'b1, sftp_pkg::OFS_REL, 32'hFFFF, 32'h0, 1'b0);
    apb(1'b0, sftp_pkg::OFS_REL, 32'h0, 32'hFFFFFFFF, 1'b0);
    $display("test registers done");
    // ports 5,6,7 become types A, B, D
    apb(1'b1, sftp_pkg::OFS_CFG, 32'h0000D2AA, 32'h0, 1'b0);
    apb(1'b0, sftp_pkg::OFS_CFG, 32'h0000D2AA, 32'hFFFFFFFF, 1'b0);
    rnd = lfsr(rnd);
    apb(1'b1, sftp_pkg::OFS_OUT, {24'h0, rnd[7:0]}, 32'h0, 1'b0);
    apb(1'b0, sftp_pkg::OFS_OUT, {24'h0, rnd[7:0]}, 32'hFFFFFFFF, 1'b0);
    repeat (3) @(posedge CLK);
    chk(DO_OUT === rnd[7:0], "safety outputs");
    chk(TP_OUT[12] === rnd[6], "two-wire channel");
    $display("test outputs done");
    closed <= 16'h8053;
    sso_on <= 16'h0C00;
    short_en <= 1'b1;
    n = 0;
    while (SAFE_REL[0] !== 1'b1 && n < 2000) begin
      @(posedge CLK);
      n++;
    end
    chk(n >= 140 && n < 2000, "release time");
    chk((SAFE_REL & 16'h8403) === 16'h8401, "released units");
    apb(1'b0, sftp_pkg::OFS_REL, 32'h8401, 32'h8403, 1'b0);
    $display("test filter done");
    for (int i = 0; i < 900; i++) begin
      @(posedge CLK);
      chk(TP_OUT[11:10] === 2'b11, "steady supply");
    end
    apb(1'b0, sftp_pkg::OFS_FAULT, 32'h01000010, 32'h0D000010, 1'b0);
    closed <= 16'h8043;
    repeat (60) @(posedge CLK);
    apb(1'b1, sftp_pkg::OFS_FAULT, 32'h10, 32'h0, 1'b0);
    apb(1'b0, sftp_pkg::OFS_FAULT, 32'h0, 32'h10, 1'b0);
    $display("test faults done");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      DIAG_IN <= {3'h0, i[0], rnd[3:0]};
      repeat (30) @(posedge CLK);
    end
    apb(1'b0, sftp_pkg::OFS_DIAG, 32'h100, 32'hF00, 1'b0);
    // aux detect drops only after 50 quiet slots
    repeat (1100) @(posedge CLK);
    apb(1'b0, sftp_pkg::OFS_DIAG, {24'h0, DIAG_IN}, 32'hFFF, 1'b0);
    $display("test aux done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    chk(1'b0, "timeout");
    summarize();
  end
endmodule
`default_nettype wire
